// ==== rtl/lfdc_control.sv ====
// LED flash driver control: power-up sequence, mode change, reference and fault reactions.
// Assumes all inputs are synchronous to clk; analog comparators arrive as clean levels.
//
// Contract
// RL1: After enable rises, wait wake-up interval, soft start, then regulate.
// RL2: After soft start, begin in linear pass mode regulating on feedback.
// RL3: Feedback low over 32 consecutive cycles in linear mode switches to doubler mode.
// RL4: Doubler mode exits only on enable toggle, select fall, power cycle, thermal fault; code also exits on flash timeout and adjustable low-time shutdown.
// RL5: Fixed variant reference 160mV with select high, 60mV with select low.
// RL6: Fixed variant is switched on and off by its own enable input.
// RL7: Fixed flash on time capped 3.5s; select or enable activity re-enables.
// RL8: Adjustable variant counts pulse edges, 10mV steps, saturating at 360mV.
// RL9: Adjustable variant shuts down when pulse input stays low over 200us.
// RL10: Edge one wakes, two sets zero, three sets 60mV, later edges add steps.
// RL11: Reference only rises; lower level needs low-time shutdown to clear count.
// RL12: Adjustable variant limits on time to 3.5s at reference 120mV or more.
// RL13: After flash timeout, stay off until enable goes low then high; code also releases on select change or adjustable low-time shutdown.
// RL14: Over-temperature turns switches off; recovery restarts through soft start.
// RL15: Over-voltage holds all switches off while it lasts.
// RL16: Over-current switches the output switches off.
// RL17: Host waits 600us after power before the first pulse.
// RL18: Host spaces first and second pulses about 25us, at most 75us.
// RL19: Host pulse train no faster than 1MHz.
// RL20: Host holds pulse input high to keep level; long low shuts down.
// RL21: Any shutdown returns to linear mode and restarts with soft start.
`timescale 1ns/100ps

module lfdc_control
    import lfdc_pkg::*;
#(
    parameter int WAKE_CYCLES = lfdc_pkg::WAKE_CYC,         // Wake-up count
    parameter longint FLASH_CYCLES = lfdc_pkg::FLASH_CYC    // Flash limit count
)
(
    input wire logic clk,                  // 10 MHz core clock
    input wire logic reset_n,              // Power-on reset, active low
    input wire logic adjustableVariant,    // 1 selects pulse-count variant
    input wire logic enable,               // Enable input, fixed variant
    input wire logic flashSelect,          // Flash/torch select, fixed variant
    input wire logic pulseCount,           // Pulse-count input, adjustable variant
    input wire logic feedbackLow,          // Feedback below reference
    input wire logic overTemp,             // Over-temperature, hysteretic level
    input wire logic overVoltage,          // Output above over-voltage threshold
    input wire logic overCurrent,          // Averaged output over current limit
    output logic [8:0] feedbackReferenceLevel, // Reference in mV
    output logic switchesOn,               // Output switches allowed
    output logic softStart,                // Soft-start phase active
    output logic linearPassMode,           // Linear pass mode active
    output logic doublerPumpMode,          // Doubler pump mode active
    output logic timedOut                  // Flash timeout latched
);
    import lfdc_pkg::*;

    lfdc_state_e state;
    logic enablePrev;
    logic selectPrev;
    logic pulsePrev;
    logic [5:0] edgeCount;
    logic [31:0] lowCount;
    logic [31:0] seqCount;
    logic [5:0] dropCount;
    logic [35:0] onCount;
    logic lowShutdown;
    logic runRequest;
    logic selectFall;
    logic enableToggle;
    logic limitActive;
    logic [8:0] next_reference;

    function automatic logic [8:0] edgeToRef(input logic [5:0] edges);
        logic [8:0] steps;
        steps = 9'(edges - EDGE_BASE);
        if (edges < EDGE_BASE)
            edgeToRef = 9'h000;
        else
            edgeToRef = 9'(REF_BASE_MV + steps * REF_STEP_MV);
    endfunction : edgeToRef

    assign selectFall = selectPrev && !flashSelect;
    assign enableToggle = enablePrev != enable;
    // RL9 low-time shutdown
    assign lowShutdown = adjustableVariant && !pulseCount && (lowCount >= 32'(LOWSD_CYC));
    // RL6 enable or pulse activity
    assign runRequest = adjustableVariant ? (edgeCount != 6'h00 && !lowShutdown) : enable;

    // Input history
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enablePrev <= 1'b0;
            selectPrev <= 1'b0;
            // Line may idle high across reset; count no edge until it is seen low
            pulsePrev <= 1'b1;
        end
        else
        begin
            enablePrev <= enable;
            selectPrev <= flashSelect;
            pulsePrev <= pulseCount;
        end
    end

    // RL9 low-time timer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            lowCount <= 32'h0000_0000;
        else if (pulseCount)
            lowCount <= 32'h0000_0000;
        else if (lowCount < 32'(LOWSD_CYC))
            lowCount <= lowCount + 32'h0000_0001;
    end

    // RL8 RL10 RL11 edge counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            edgeCount <= 6'h00;
        else if (!adjustableVariant || lowShutdown)
            edgeCount <= 6'h00;
        else if (pulseCount && !pulsePrev && edgeCount < EDGE_MAX)
            edgeCount <= edgeCount + 6'h01;
    end

    // RL5 RL8 reference select
    always_comb
    begin
        if (adjustableVariant)
            next_reference = edgeToRef(edgeCount);
        else
            next_reference = flashSelect ? REF_FLASH_MV : REF_TORCH_MV;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            feedbackReferenceLevel <= 9'h000;
        else
            feedbackReferenceLevel <= next_reference;
    end

    // RL7 RL12 timeout applies
    assign limitActive = adjustableVariant ? (next_reference >= REF_LIMIT_MV) : flashSelect;

    // RL7 RL12 RL13 on-time limit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            onCount <= 36'h0_0000_0000;
        else if ((state == LFDC_LIN || state == LFDC_DBL) && limitActive)
        begin
            if (onCount < 36'(FLASH_CYCLES))
                onCount <= onCount + 36'h0_0000_0001;
        end
        else
            onCount <= 36'h0_0000_0000;
    end

    // RL13 timeout latch and release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            timedOut <= 1'b0;
        else if (onCount >= 36'(FLASH_CYCLES) && limitActive)
            timedOut <= 1'b1;
        else if (adjustableVariant ? lowShutdown : (!enable || (flashSelect != selectPrev)))
            timedOut <= 1'b0;
    end

    // RL3 dropout counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dropCount <= 6'h00;
        else if (state == LFDC_LIN && feedbackLow && !overVoltage && !overCurrent)
            dropCount <= (dropCount < DROPOUT_CYC) ? dropCount + 6'h01 : dropCount;
        else
            dropCount <= 6'h00;
    end

    // RL1 RL4 RL14 RL21 sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= LFDC_OFF;
            seqCount <= 32'h0000_0000;
        end
        else if (!runRequest || timedOut || overTemp)
        begin
            // RL21 back to linear via restart
            state <= LFDC_OFF;
            seqCount <= 32'h0000_0000;
        end
        else
        begin
            unique case (state)
                LFDC_OFF:
                begin
                    state <= LFDC_WAKE;
                    seqCount <= 32'h0000_0000;
                end
                LFDC_WAKE:
                begin
                    seqCount <= seqCount + 32'h0000_0001;
                    if (seqCount >= 32'(WAKE_CYCLES - 1))
                    begin
                        state <= LFDC_SOFT;
                        seqCount <= 32'h0000_0000;
                    end
                end
                LFDC_SOFT:
                begin
                    seqCount <= seqCount + 32'h0000_0001;
                    // RL2 start linear
                    if (seqCount >= 32'(SOFT_CYC - 1))
                        state <= LFDC_LIN;
                end
                LFDC_LIN:
                    // RL3 dropout switch
                    if (dropCount >= DROPOUT_CYC)
                        state <= LFDC_DBL;
                LFDC_DBL:
                    // RL4 doubler exits
                    if (enableToggle || (!adjustableVariant && selectFall))
                        state <= LFDC_LIN;
            endcase
        end
    end

    assign softStart = state == LFDC_SOFT;
    assign linearPassMode = state == LFDC_LIN;
    assign doublerPumpMode = state == LFDC_DBL;
    // RL14 RL15 RL16 switch gating
    assign switchesOn = (state == LFDC_SOFT || state == LFDC_LIN || state == LFDC_DBL)
        && !overTemp && !overVoltage && !overCurrent;

    sequence s_dropRun;
        (linearPassMode && feedbackLow && !overVoltage && !overCurrent && runRequest
            && !timedOut && !overTemp)[*8];
    endsequence

    property p_dropSwitch;
        @(posedge clk) disable iff (!reset_n)
        (linearPassMode && dropCount == 6'd32 && runRequest && !timedOut && !overTemp)
            |=> doublerPumpMode;
    endproperty
    a_dropSwitch: assert property (p_dropSwitch) else $error("no switch after dropout"); // RL3

    property p_noEarlyDouble;
        @(posedge clk) disable iff (!reset_n)
        $rose(doublerPumpMode) |-> $past(dropCount) == 6'd32;
    endproperty
    a_noEarlyDouble: assert property (p_noEarlyDouble) else $error("early doubler entry"); // RL3

    property p_dropCount;
        @(posedge clk) disable iff (!reset_n)
        ($rose(linearPassMode) ##0 s_dropRun) |-> dropCount == 6'd7;
    endproperty
    a_dropCount: assert property (p_dropCount) else $error("dropout count wrong"); // RL3

    property p_softAfterWake;
        @(posedge clk) disable iff (!reset_n)
        $rose(softStart) |-> $past(state) == LFDC_WAKE;
    endproperty
    a_softAfterWake: assert property (p_softAfterWake) else $error("soft start skipped wake"); // RL1

    property p_linAfterSoft;
        @(posedge clk) disable iff (!reset_n)
        ($rose(linearPassMode) && !$past(doublerPumpMode)) |-> $past(softStart);
    endproperty
    a_linAfterSoft: assert property (p_linAfterSoft) else $error("linear without soft start"); // RL2

    property p_fixedRef;
        @(posedge clk) disable iff (!reset_n)
        (!adjustableVariant && reset_n)
            |=> feedbackReferenceLevel == ($past(flashSelect) ? 9'd160 : 9'd60);
    endproperty
    a_fixedRef: assert property (p_fixedRef) else $error("fixed reference wrong"); // RL5

    property p_refSat;
        @(posedge clk) disable iff (!reset_n)
        adjustableVariant |-> feedbackReferenceLevel <= 9'd360;
    endproperty
    a_refSat: assert property (p_refSat) else $error("reference above 360mV"); // RL8

    property p_refRise;
        @(posedge clk) disable iff (!reset_n)
        (adjustableVariant && $past(adjustableVariant) && $past(edgeCount) != 6'd0 && edgeCount != 6'd0)
            |-> edgeCount >= $past(edgeCount);
    endproperty
    a_refRise: assert property (p_refRise) else $error("reference count fell"); // RL11

    property p_faultOff;
        @(posedge clk) disable iff (!reset_n)
        (overVoltage || overCurrent || overTemp) |-> !switchesOn;
    endproperty
    a_faultOff: assert property (p_faultOff) else $error("switches on during fault"); // RL15

    property p_thermalRestart;
        @(posedge clk) disable iff (!reset_n)
        overTemp |=> state == LFDC_OFF;
    endproperty
    a_thermalRestart: assert property (p_thermalRestart) else $error("no restart on thermal"); // RL14

    property p_timeoutOff;
        @(posedge clk) disable iff (!reset_n)
        timedOut |=> !switchesOn;
    endproperty
    a_timeoutOff: assert property (p_timeoutOff) else $error("running after timeout"); // RL13

endmodule : lfdc_control

// ==== rtl/lfdc_pkg.sv ====
// Package for the flash driver control block: timing counts, reference codes, states.
// Assumes a 10 MHz core clock; reference levels are in millivolts.
package lfdc_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // Reference wake-up interval
    localparam int WAKE_US = 200;
    localparam int WAKE_CYC = (WAKE_US * 1000) / CLK_NS;
    // Soft-start duration, a plain default
    localparam int SOFT_US = 100;
    localparam int SOFT_CYC = (SOFT_US * 1000) / CLK_NS;
    // Dropout detector: cycles below regulation before doubling
    localparam logic [5:0] DROPOUT_CYC = 6'd32;
    // Low time on the pulse-count input that forces shutdown
    localparam int LOWSD_US = 200;
    localparam int LOWSD_CYC = (LOWSD_US * 1000) / CLK_NS;
    // Flash on-time limit
    localparam longint FLASH_MS = 3500;
    localparam longint FLASH_CYC = (FLASH_MS * 1_000_000) / CLK_NS;
    // Reference levels, millivolts
    localparam logic [8:0] REF_FLASH_MV = 9'd160;
    localparam logic [8:0] REF_TORCH_MV = 9'd60;
    localparam logic [8:0] REF_BASE_MV = 9'd60;
    localparam logic [8:0] REF_STEP_MV = 9'd10;
    localparam logic [8:0] REF_LIMIT_MV = 9'd120;
    // Edge count: 1 wake, 2 zero, 3 base level, up to 3+30 steps
    localparam logic [5:0] EDGE_ZERO = 6'd2;
    localparam logic [5:0] EDGE_BASE = 6'd3;
    localparam logic [5:0] EDGE_MAX = 6'd33;

    typedef enum logic [4:0] {
        LFDC_OFF = 5'b00001,
        LFDC_WAKE = 5'b00010,
        LFDC_SOFT = 5'b00100,
        LFDC_LIN = 5'b01000,
        LFDC_DBL = 5'b10000
    } lfdc_state_e;

endpackage : lfdc_pkg

// ==== tb/lfdc_host_model.sv ====
// Host model: drives the enable, select and pulse-count lines of the flash driver.
// Assumes the bench shares clk and the power-on reset with the device.
`timescale 1ns/100ps

module lfdc_host_model
(
    input wire logic clk, // Core clock
    input wire logic reset_n, // Power cycle, active low
    output logic enable, // Enable line
    output logic flashSelect, // Flash/torch select
    output logic pulseCount // Pulse-count line
);
    int upCycles;

    initial
    begin
        enable = 1'b0;
        flashSelect = 1'b0;
        pulseCount = 1'b0;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            upCycles <= 0;
        else if (upCycles < 6000)
            upCycles <= upCycles + 1;
    end

    task setLevels(input logic en, input logic sel);
        @(posedge clk);
        enable <= en;
        flashSelect <= sel;
    endtask : setLevels

    task holdLow(input int n);
        @(posedge clk);
        pulseCount <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : holdLow

    task sendPulses(input int n);
        while (upCycles < 6000) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            pulseCount <= 1'b0;
            repeat (i == 1 ? 244 : 4) @(posedge clk);
            pulseCount <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask : sendPulses
endmodule : lfdc_host_model

// ==== tb/test_lfdc_control.sv ====
// Self-checking bench for the flash driver control block.
// Assumes shortened wake and flash counts; the host model drives the control lines.
`timescale 1ns/100ps

module test_lfdc_control;
    import lfdc_pkg::*;
    localparam int WAKE = 20;
    localparam longint FLASHC = 500;
    localparam int LIMIT = 90000;
    localparam int SW = 0, SOFT = 1, LIN = 2, DBL = 3, TO = 4;
    typedef struct {logic variant; logic sel; int pulses; logic [8:0] level;} lfdc_row_s;
    lfdc_row_s rows [7] = '{'{1'b0, 1'b1, 0, 9'h0A0}, '{1'b0, 1'b0, 0, 9'h03C},
        '{1'b1, 1'b0, 2, 9'h000}, '{1'b1, 1'b0, 3, 9'h03C}, '{1'b1, 1'b0, 5, 9'h050},
        '{1'b1, 1'b0, 33, 9'h168}, '{1'b1, 1'b0, 36, 9'h168}};
    logic clk = 1'b0;
    logic reset_n, adjustableVariant, feedbackLow, overTemp, overVoltage, overCurrent;
    logic enable, flashSelect, pulseCount;
    logic [8:0] feedbackReferenceLevel;
    logic switchesOn, softStart, linearPassMode, doublerPumpMode, timedOut;
    wire logic [4:0] flags = {timedOut, doublerPumpMode, linearPassMode, softStart, switchesOn};
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    lfdc_host_model host_u (.clk(clk), .reset_n(reset_n), .enable(enable),
        .flashSelect(flashSelect), .pulseCount(pulseCount));
    lfdc_control #(.WAKE_CYCLES(WAKE), .FLASH_CYCLES(FLASHC)) dut_u (.clk(clk),
        .reset_n(reset_n), .adjustableVariant(adjustableVariant), .enable(enable),
        .flashSelect(flashSelect), .pulseCount(pulseCount), .feedbackLow(feedbackLow),
        .overTemp(overTemp), .overVoltage(overVoltage), .overCurrent(overCurrent),
        .feedbackReferenceLevel(feedbackReferenceLevel), .switchesOn(switchesOn),
        .softStart(softStart), .linearPassMode(linearPassMode),
        .doublerPumpMode(doublerPumpMode), .timedOut(timedOut));

    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_errors++;
            $display("[FAIL] %0t watchdog expired", $time);
            final_report();
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task checkBit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %b", $time, what, got);
        end
    endtask : checkBit

    task checkRef(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : checkRef

    task waitFor(input int idx, input logic lvl, input int lim);
        n = 1;
        @(posedge clk);
        #1;
        while (flags[idx] !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        checkBit(flags[idx], lvl, "wait expired");
    endtask : waitFor

    task setFaults(input logic [2:0] f);
        @(posedge clk);
        {overTemp, overVoltage, overCurrent} <= f;
    endtask : setFaults

    task powerCycle(input logic adj);
        host_u.setLevels(1'b0, 1'b0);
        reset_n <= 1'b0;
        adjustableVariant <= adj;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
    endtask : powerCycle

    initial
    begin
        reset_n = 1'b0;
        adjustableVariant = 1'b0;
        feedbackLow = 1'b0;
        overTemp = 1'b0;
        overVoltage = 1'b0;
        overCurrent = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        checkRef(feedbackReferenceLevel, 9'h000, "reset level");
        checkBit(switchesOn | linearPassMode, 1'b0, "reset flags");
        @(posedge clk) reset_n <= 1'b1;
        $display("test reset done");
        foreach (rows[i])
        begin
            powerCycle(rows[i].variant);
            if (rows[i].variant)
                host_u.sendPulses(rows[i].pulses);
            else
                host_u.setLevels(1'b1, rows[i].sel);
            repeat (2) @(posedge clk);
            #1;
            checkRef(feedbackReferenceLevel, rows[i].level, "row level");
        end
        $display("test table done");
        powerCycle(1'b0);
        host_u.setLevels(1'b1, 1'b0);
        waitFor(SOFT, 1'b1, WAKE + 10);
        checkBit(n >= WAKE, 1'b1, "wake too short");
        waitFor(LIN, 1'b1, SOFT_CYC + 10);
        @(posedge clk) feedbackLow <= 1'b1;
        repeat (31) @(posedge clk);
        feedbackLow <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        checkBit(doublerPumpMode, 1'b0, "early doubler");
        @(posedge clk) feedbackLow <= 1'b1;
        waitFor(DBL, 1'b1, 40);
        checkBit(n >= 33, 1'b1, "doubler too soon");
        @(posedge clk) feedbackLow <= 1'b0;
        setFaults(3'b010);
        repeat (3) @(posedge clk);
        #1;
        checkBit(switchesOn, 1'b0, "switches on in overvoltage");
        checkBit(doublerPumpMode, 1'b1, "doubler left");
        setFaults(3'b000);
        waitFor(SW, 1'b1, 5);
        host_u.setLevels(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        checkBit(doublerPumpMode, 1'b1, "doubler left on rise");
        host_u.setLevels(1'b1, 1'b0);
        waitFor(DBL, 1'b0, 5);
        $display("test dropout done");
        setFaults(3'b001);
        waitFor(SW, 1'b0, 5);
        setFaults(3'b000);
        waitFor(SW, 1'b1, 5);
        setFaults(3'b100);
        waitFor(SW, 1'b0, 5);
        setFaults(3'b000);
        feedbackLow <= 1'b1;
        waitFor(SOFT, 1'b1, WAKE + 10);
        waitFor(LIN, 1'b1, SOFT_CYC + 10);
        // Dropout counting from the first linear cycle, short of the switch point
        repeat (8) @(posedge clk);
        feedbackLow <= 1'b0;
        #1;
        checkBit(linearPassMode, 1'b1, "linear after restart");
        $display("test faults done");
        host_u.setLevels(1'b1, 1'b1);
        waitFor(TO, 1'b1, FLASHC + 20);
        checkBit(n >= FLASHC, 1'b1, "early timeout");
        repeat (2) @(posedge clk);
        #1;
        checkBit(switchesOn, 1'b0, "on after timeout");
        host_u.setLevels(1'b0, 1'b1);
        host_u.setLevels(1'b1, 1'b1);
        waitFor(SOFT, 1'b1, WAKE + 10);
        waitFor(TO, 1'b1, FLASHC + SOFT_CYC + 40);
        host_u.setLevels(1'b1, 1'b0);
        waitFor(SOFT, 1'b1, WAKE + 10);
        $display("test timeout done");
        powerCycle(1'b1);
        host_u.sendPulses(6);
        waitFor(LIN, 1'b1, WAKE + SOFT_CYC + 20);
        checkRef(feedbackReferenceLevel, 9'h05A, "six pulses");
        host_u.holdLow(1900);
        host_u.sendPulses(1);
        #1;
        checkRef(feedbackReferenceLevel, 9'h064, "short low");
        checkBit(linearPassMode, 1'b1, "short low shut down");
        checkBit(timedOut, 1'b0, "timeout below limit");
        host_u.sendPulses(2);
        waitFor(TO, 1'b1, FLASHC + 20);
        host_u.holdLow(2100);
        #1;
        checkBit(linearPassMode | timedOut, 1'b0, "low time");
        host_u.sendPulses(4);
        #1;
        checkRef(feedbackReferenceLevel, 9'h046, "lower level");
        waitFor(LIN, 1'b1, WAKE + SOFT_CYC + 20);
        $display("test adjustable done");
        final_report();
    end
endmodule : test_lfdc_control
